//--- logic/qei_wrap.sv
// Quadrature encoder wrapper: clock gating, input conditioning, error mux and two units.
//
// The register addresses and the AXI4-Lite register port were decided locally.

module qei_wrap (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // AXI4-Lite write
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Encoder pins, one set per unit
    input  wire qei_pkg::qei_pins_t    encPins [qei_pkg::NUM_UNITS],
    // Unit results
    output qei_pkg::qei_unit_out_t     unitOut [qei_pkg::NUM_UNITS],
    // Active-low phase error toward the high-end timer
    output logic                       phaseErrTimer_n
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0]       clkDis_q;
    logic [31:0]       inSel_q;
    logic              errSel_q;
    logic [qei_pkg::FILT_W-1:0] filtWidth_q;
    logic              encClkEn;
    wire  [qei_pkg::NUM_UNITS-1:0] errVec;
    logic [qei_pkg::NUM_UNITS-1:0] errSticky_q;

    // Write channel: address and data are latched independently in any order.
    logic              awHeld_q;
    logic              wHeld_q;
    logic [7:0]        awAddr_q;
    logic [31:0]       wData_q;
    logic [3:0]        wStrb_q;
    logic              doWrite;
    logic [31:0]       rdMux;
    logic              rdHit;
    logic              wrHit;

    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
    assign doWrite       = awHeld_q && wHeld_q && !s_axi_bvalid;
    assign wrHit = (awAddr_q == qei_pkg::CLK_DIS_ADDR) || (awAddr_q == qei_pkg::IN_SEL_ADDR)
                || (awAddr_q == qei_pkg::ERR_SEL_ADDR) || (awAddr_q == qei_pkg::FILT_ADDR)
                || (awAddr_q == qei_pkg::STATUS_ADDR);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= qei_pkg::RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? qei_pkg::RESP_OKAY : qei_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Clock disable register resets to zero so the encoder clock runs.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clkDis_q <= qei_pkg::CLK_DIS_RESET;
        end else if (doWrite && awAddr_q == qei_pkg::CLK_DIS_ADDR) begin
            clkDis_q <= merge(clkDis_q, wData_q, wStrb_q);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            inSel_q <= qei_pkg::IN_SEL_RESET;
        end else if (doWrite && awAddr_q == qei_pkg::IN_SEL_ADDR) begin
            inSel_q <= merge(inSel_q, wData_q, wStrb_q);
        end
    end

    // The selection only changes on a software write.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            errSel_q <= 1'b0;
        end else if (doWrite && awAddr_q == qei_pkg::ERR_SEL_ADDR && wStrb_q[0]) begin
            errSel_q <= wData_q[0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            filtWidth_q <= qei_pkg::FILT_RESET;
        end else if (doWrite && awAddr_q == qei_pkg::FILT_ADDR && wStrb_q[0]) begin
            filtWidth_q <= wData_q[qei_pkg::FILT_W-1:0];
        end
    end

    // Sticky phase errors: a new error wins over a write-one-to-clear.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            errSticky_q <= '0;
        end else begin
            for (int u = 0; u < qei_pkg::NUM_UNITS; u++) begin
                if (errVec[u]) begin
                    errSticky_q[u] <= 1'b1;
                end else if (doWrite && awAddr_q == qei_pkg::STATUS_ADDR
                             && wStrb_q[0] && wData_q[u]) begin
                    errSticky_q[u] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    always_comb begin
        rdHit = 1'b1;
        unique case (s_axi_araddr)
            qei_pkg::CLK_DIS_ADDR: rdMux = clkDis_q;
            qei_pkg::IN_SEL_ADDR:  rdMux = inSel_q;
            qei_pkg::ERR_SEL_ADDR: rdMux = {31'h0000_0000, errSel_q};
            qei_pkg::STATUS_ADDR:  rdMux = {28'h000_0000, errVec, errSticky_q};
            qei_pkg::FILT_ADDR:    rdMux = {28'h000_0000, filtWidth_q};
            default: begin
                rdMux = 32'h0000_0000;
                rdHit = 1'b0;
            end
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= qei_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdMux;
            s_axi_rresp  <= rdHit ? qei_pkg::RESP_OKAY : qei_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Encoder units
    // ------------------------------------------------------------------
    // A clock enable term stands in for the gated clock, so no glitchy gate sits on sys_clk.
    assign encClkEn = !clkDis_q[qei_pkg::ENC_CLK_DIS_BIT];

    for (genvar u = 0; u < qei_pkg::NUM_UNITS; u++) begin : g_unit
        qei_unit u_unit (
            .sys_clk   (sys_clk),
            .rst       (rst),
            .clkEn     (encClkEn),
            .inSel     (inSel_q),
            .filtWidth (filtWidth_q),
            .pins      (encPins[u]),
            .result    (unitOut[u])
        );
        assign errVec[u] = unitOut[u].phaseErr;
    end

    // Selected error is inverted for the timer input.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phaseErrTimer_n <= 1'b1;
        end else begin
            phaseErrTimer_n <= !errVec[errSel_q];
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_err_inverted: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 phaseErrTimer_n == !$past(errVec[errSel_q]))
        else $error("Timer phase error is not the inverted selected error.");

    a_err_sel_stable: assert property (@(posedge sys_clk) disable iff (rst)
        !(doWrite && awAddr_q == qei_pkg::ERR_SEL_ADDR) |=> $stable(errSel_q))
        else $error("Error selection changed without a write.");

    a_clk_gate_bit: assert property (@(posedge sys_clk) disable iff (rst)
        clkDis_q[qei_pkg::ENC_CLK_DIS_BIT] |-> !encClkEn)
        else $error("Encoder clock runs while disabled.");

    a_clk_reset_run: assert property (@(posedge sys_clk)
        $fell(rst) |-> encClkEn)
        else $error("Encoder clock not running after reset.");

    a_err_mux_pick: assert property (@(posedge sys_clk) disable iff (rst)
        (errVec[0] && !errVec[1] && !errSel_q) |=> !phaseErrTimer_n)
        else $error("Selected unit 0 error not forwarded.");

endmodule : qei_wrap

// One encoder unit: input conditioning, decoder, counter and compare sync.
module qei_unit (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    input  wire logic                          clkEn,
    // Configuration
    input  wire logic [31:0]                   inSel,
    input  wire logic [qei_pkg::FILT_W-1:0]    filtWidth,
    // Pins and result
    input  wire qei_pkg::qei_pins_t            pins,
    output qei_pkg::qei_unit_out_t             result
);

    logic [qei_pkg::NUM_INPUTS-1:0] raw;
    logic [qei_pkg::NUM_INPUTS-1:0] syncA_q;
    logic [qei_pkg::NUM_INPUTS-1:0] syncB_q;
    logic [qei_pkg::NUM_INPUTS-1:0] filt_q;
    logic [qei_pkg::NUM_INPUTS-1:0] cond;
    logic [qei_pkg::NUM_INPUTS-1:0] cond_q;
    logic [qei_pkg::FILT_W-1:0]     filtCnt_q [qei_pkg::NUM_INPUTS];
    logic                           illegal;
    logic                           step;
    logic                           dirUp;

    assign raw = {pins.strobe, pins.idx, pins.b, pins.a};

    // Two-flop synchroniser; the first stage feeds only the second.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            syncA_q <= '0;
            syncB_q <= '0;
        end else begin
            syncA_q <= raw;
            syncB_q <= syncA_q;
        end
    end

    // The filter passes a level only after it stands for filtWidth + 1 cycles.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            filt_q <= '0;
            for (int i = 0; i < qei_pkg::NUM_INPUTS; i++) begin
                filtCnt_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < qei_pkg::NUM_INPUTS; i++) begin
                if (syncB_q[i] == filt_q[i]) begin
                    filtCnt_q[i] <= '0;
                end else if (filtCnt_q[i] >= filtWidth) begin
                    filt_q[i]    <= syncB_q[i];
                    filtCnt_q[i] <= '0;
                end else begin
                    filtCnt_q[i] <= filtCnt_q[i] + 1'b1;
                end
            end
        end
    end

    // Path selection per input; with neither bit set the input is held low.
    always_comb begin
        for (int i = 0; i < qei_pkg::NUM_INPUTS; i++) begin
            if (inSel[i*qei_pkg::SEL_STRIDE + qei_pkg::SEL_SYNC_OFS]) begin
                cond[i] = syncB_q[i];
            end else if (inSel[i*qei_pkg::SEL_STRIDE + qei_pkg::SEL_FILT_OFS]) begin
                cond[i] = filt_q[i];
            end else begin
                cond[i] = 1'b0;
            end
        end
    end

    // Both A and B changing at once is an illegal quadrature step.
    assign illegal = (cond[0] != cond_q[0]) && (cond[1] != cond_q[1]);
    assign step    = (cond[0] != cond_q[0]) ^ (cond[1] != cond_q[1]);
    assign dirUp   = (cond[0] ^ cond_q[1]);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cond_q          <= '0;
            result.cnt      <= 32'h0000_0000;
            result.phaseErr <= 1'b0;
            result.cmpSync  <= 1'b0;
        end else if (clkEn) begin
            cond_q          <= cond;
            result.phaseErr <= illegal;
            // On the synchronised path, counting lands three cycles after the pin edge, inside the bound.
            if (step) begin
                result.cnt <= dirUp ? result.cnt + 32'h0000_0001 : result.cnt - 32'h0000_0001;
            end
            result.cmpSync <= step;
        end
    end

    a_cnt_latency: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && step) |=> result.cnt != $past(result.cnt))
        else $error("Counter did not step after a quadrature edge.");

    a_cmp_latency: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && step) |=> result.cmpSync)
        else $error("Compare sync did not answer the input edge.");

    a_sync_path: assert property (@(posedge sys_clk) disable iff (rst)
        inSel[0] |-> cond[0] == syncB_q[0])
        else $error("Input A not on synchronized path.");

endmodule : qei_unit

//--- logic/qei_pkg.sv
// Package of constants, register map and carrier types for the quadrature encoder wrapper.
package qei_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses on the AXI4-Lite slave)
    // ------------------------------------------------------------------
    localparam logic [7:0] CLK_DIS_ADDR  = 8'h00;
    localparam logic [7:0] IN_SEL_ADDR   = 8'h04;
    localparam logic [7:0] ERR_SEL_ADDR  = 8'h08;
    localparam logic [7:0] STATUS_ADDR   = 8'h0C;
    localparam logic [7:0] FILT_ADDR     = 8'h10;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          ENC_CLK_DIS_BIT = 9;
    localparam logic [31:0] CLK_DIS_RESET   = 32'h0000_0000;
    localparam logic [31:0] IN_SEL_RESET    = 32'h0101_0101;
    localparam int          SEL_SYNC_OFS    = 0;
    localparam int          SEL_FILT_OFS    = 1;
    localparam int          SEL_STRIDE      = 8;
    localparam int          NUM_INPUTS      = 4;
    localparam int          NUM_UNITS       = 2;
    localparam int          FILT_W          = 4;
    localparam logic [FILT_W-1:0] FILT_RESET = 4'h3;

    // ------------------------------------------------------------------
    // Timing figures in peripheral clock cycles
    // ------------------------------------------------------------------
    localparam int MIN_PERIOD_CYC = 2;
    localparam int CNT_DELAY_MAX  = 4;
    localparam int CMP_DELAY_MAX  = 6;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic idx;
        logic strobe;
        logic b;
        logic a;
    } qei_pins_t;

    typedef struct packed {
        logic [31:0] cnt;
        logic        phaseErr;
        logic        cmpSync;
    } qei_unit_out_t;

endpackage : qei_pkg

//--- testbench/qei_enc_model.sv
// Behavioural incremental encoder that drives the pins of one encoder unit.
module qei_enc_model (
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst,
    // Step command
    input  wire logic          go,
    input  wire logic [1:0]    mode,
    input  wire logic [3:0]    holdCyc,
    // Encoder pins
    output qei_pkg::qei_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] phase_q;
    logic [3:0] wait_q;
    logic [1:0] phase_d;

    // Mode 2 jumps two phases, so A and B move together: a deliberate phase fault.
    always_comb begin
        phase_d = (mode == 2'h0) ? phase_q + 2'h1 : (mode == 2'h1) ? phase_q - 2'h1 : phase_q + 2'h2;
    end

    // Commands that arrive while a level is still being held are ignored.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phase_q <= 2'h0;
            wait_q  <= 4'h0;
            pins    <= '0;
        end else if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
        end else if (go) begin
            phase_q     <= phase_d;
            wait_q      <= holdCyc;
            pins.a      <= phase_d[1] ^ phase_d[0];
            pins.b      <= phase_d[1];
            pins.strobe <= ~pins.strobe;
            pins.idx    <= (phase_d == 2'h0);
        end
    end
endmodule : qei_enc_model

//--- testbench/qei_wrap_bench.sv
// Self-checking bench for the quadrature encoder wrapper.
module qei_wrap_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   sys_clk;
    logic                   rst;
    logic [7:0]             s_axi_awaddr, s_axi_araddr;
    logic [31:0]            s_axi_wdata, s_axi_rdata;
    logic [3:0]             s_axi_wstrb;
    logic [1:0]             s_axi_bresp, s_axi_rresp;
    logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                   s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                   s_axi_rvalid, s_axi_rready, phaseErrTimer_n;
    qei_pkg::qei_pins_t     encPins [qei_pkg::NUM_UNITS];
    qei_pkg::qei_unit_out_t unitOut [qei_pkg::NUM_UNITS];
    logic [1:0]             encGo, encMode;
    logic [3:0]             encHold;
    logic [33:0]            rdExp [$];
    logic [1:0]             bExp [$];
    int                     failures = 0, n_checks = 0, cycles = 0, seed;
    int                     lc, ls, le, lt, hold;
    logic [31:0]            sels [3] = '{32'h0000_0000, 32'h0202_0202, 32'h0303_0303};
    int                     loLat [3] = '{0, 5, 1};
    int                     hiLat [3] = '{0, 12, 4};

    qei_wrap qei_wrap_i (
        .sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .encPins, .unitOut, .phaseErrTimer_n
    );

    for (genvar u = 0; u < qei_pkg::NUM_UNITS; u++) begin : gen_enc
        qei_enc_model qei_enc_model_i (
            .sys_clk, .rst, .go(encGo[u]), .mode(encMode), .holdCyc(encHold),
            .pins(encPins[u])
        );
    end

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // Checking and reporting
    // ------------------------------------------------------------------
    task automatic check(input string nm, input logic [33:0] exp, input logic [33:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : check

    task automatic check_span(input string nm, input int v, input int lo, input int hi);
        check(nm, 34'h1, {33'h0, (v >= lo && v <= hi)});
    endtask : check_span

    task automatic print_verdict();
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    // Answers are compared here, in the order the requests were noted.
    always @(posedge sys_clk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
            check("read word", rdExp.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
            check("write response", {32'h0, bExp.pop_front()}, {32'h0, s_axi_bresp});
    end

    // The whole run needs well under a thousand cycles.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Bus and encoder drivers
    // ------------------------------------------------------------------
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bit aw, w, b;
        aw = 1;
        w = 1;
        b = 1;
        bExp.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (b) begin
            @(posedge sys_clk);
            if (s_axi_awready === 1'b1) aw = 0;
            if (s_axi_wready === 1'b1) w = 0;
            if (s_axi_bvalid === 1'b1) b = 0;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
            s_axi_bready <= b;
        end
        @(posedge sys_clk);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bit ar, rr;
        ar = 1;
        rr = 1;
        rdExp.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (rr) begin
            @(posedge sys_clk);
            if (s_axi_arready === 1'b1) ar = 0;
            if (s_axi_rvalid === 1'b1) rr = 0;
            s_axi_arvalid <= ar;
            s_axi_rready <= rr;
        end
        @(posedge sys_clk);
    endtask : axi_read

    // One encoder step; reports the first cycle at which each output reacted.
    task automatic run_step(input int u, input logic [1:0] m, input int h);
        logic [31:0] old;
        old = unitOut[u].cnt;
        {lc, ls, le, lt} = '0;
        encMode <= m;
        encHold <= 4'(h);
        encGo[u] <= 1'b1;
        @(posedge sys_clk);
        encGo <= 2'h0;
        for (int k = 1; k <= 12; k++) begin
            @(posedge sys_clk);
            #1;
            if (lc == 0 && unitOut[u].cnt !== old) lc = k;
            if (ls == 0 && unitOut[u].cmpSync === 1'b1) ls = k;
            if (le == 0 && unitOut[u].phaseErr === 1'b1) le = k;
            if (lt == 0 && phaseErrTimer_n === 1'b0) lt = k;
        end
        @(posedge sys_clk);
    endtask : run_step

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 96;
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        {encGo, encMode, encHold} = 8'h02;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        axi_read(qei_pkg::CLK_DIS_ADDR, qei_pkg::CLK_DIS_RESET, qei_pkg::RESP_OKAY);
        axi_read(qei_pkg::IN_SEL_ADDR, qei_pkg::IN_SEL_RESET, qei_pkg::RESP_OKAY);
        axi_read(qei_pkg::FILT_ADDR, 32'(qei_pkg::FILT_RESET), qei_pkg::RESP_OKAY);
        axi_write(8'h14, 32'hFFFF_FFFF, qei_pkg::RESP_SLVERR);
        axi_read(8'h14, 32'h0000_0000, qei_pkg::RESP_SLVERR);
        $display("test registers finished");
        for (int u = 0; u < qei_pkg::NUM_UNITS; u++) begin
            for (int m = 0; m < 2; m++) begin
                run_step(u, 2'(m), 2 + ($random(seed) & 3));
                check_span("count delay", lc, 1, qei_pkg::CNT_DELAY_MAX);
                check_span("compare sync delay", ls, 1, qei_pkg::CMP_DELAY_MAX);
                check_span("no phase error", le + lt, 0, 0);
                check("count value", {2'b00, 32'(1 - m)}, {2'b00, unitOut[u].cnt});
            end
        end
        $display("test counting finished");
        for (int s = 0; s < qei_pkg::NUM_UNITS; s++) begin
            axi_write(qei_pkg::ERR_SEL_ADDR, 32'(s), qei_pkg::RESP_OKAY);
            axi_read(qei_pkg::ERR_SEL_ADDR, 32'(s), qei_pkg::RESP_OKAY);
            run_step(s, 2'h2, 2 + ($random(seed) & 3));
            check_span("phase error", le, 1, qei_pkg::CMP_DELAY_MAX);
            check_span("timer error", lt, le + 1, le + 1);
            run_step(1 - s, 2'h2, 2 + ($random(seed) & 3));
            check_span("other phase error", le, 1, qei_pkg::CMP_DELAY_MAX);
            check_span("unselected error", lt, 0, 0);
        end
        axi_read(qei_pkg::STATUS_ADDR, 32'h0000_0003, qei_pkg::RESP_OKAY);
        axi_write(qei_pkg::STATUS_ADDR, 32'h0000_0003, qei_pkg::RESP_OKAY);
        axi_read(qei_pkg::STATUS_ADDR, 32'h0000_0000, qei_pkg::RESP_OKAY);
        $display("test phase error finished");
        axi_write(qei_pkg::CLK_DIS_ADDR, 32'h0000_0200, qei_pkg::RESP_OKAY);
        axi_read(qei_pkg::CLK_DIS_ADDR, 32'h0000_0200, qei_pkg::RESP_OKAY);
        run_step(0, 2'h0, 2 + ($random(seed) & 3));
        check_span("frozen count", lc + ls, 0, 0);
        axi_write(qei_pkg::CLK_DIS_ADDR, 32'h0000_0000, qei_pkg::RESP_OKAY);
        repeat (12) @(posedge sys_clk);
        run_step(0, 2'h0, 2 + ($random(seed) & 3));
        check_span("resumed count", lc, 1, qei_pkg::CNT_DELAY_MAX);
        $display("test clock disable finished");
        for (int i = 0; i < 3; i++) begin
            axi_write(qei_pkg::IN_SEL_ADDR, sels[i], qei_pkg::RESP_OKAY);
            axi_read(qei_pkg::IN_SEL_ADDR, sels[i], qei_pkg::RESP_OKAY);
            repeat (12) @(posedge sys_clk);
            for (int m = 0; m < 2; m++) begin
                hold = 2 + ($random(seed) & 3) + ((i == 1) ? int'(qei_pkg::FILT_RESET) : 0);
                run_step(1, 2'h0, hold);
                check_span("path delay", lc, loLat[i], hiLat[i]);
            end
        end
        $display("test input paths finished");
        print_verdict();
    end
endmodule : qei_wrap_bench
